// [rtl/uirp_pkg.sv]
// shared constants and types of the serial / infrared / pwm controller
// assumes a single synchronous clock domain for all users
package uirp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  UIRP_CTL_ADDR  = 8'h12;
  localparam logic [7:0]  UIRP_DATA_ADDR = 8'h13;

  // ---------------------------------------------------------------
  // rates in hertz
  // ---------------------------------------------------------------
  localparam int          UIRP_BASE_HZ   = 1_843_200;
  localparam int          UIRP_PW_HZ     = 65_536_000;
  localparam int          UIRP_MAX_BAUD  = 115_200;
  localparam int          UIRP_OVS       = UIRP_BASE_HZ / UIRP_MAX_BAUD;

  // ---------------------------------------------------------------
  // data-word field positions and widths
  // ---------------------------------------------------------------
  localparam int          UIRP_PAR_EN_BIT  = 0;
  localparam int          UIRP_PAR_POL_BIT = 5;
  localparam int          UIRP_MODE_LSB    = 12;
  localparam int          UIRP_CAR_EN_BIT  = 14;
  localparam int          UIRP_SINGLE_BIT  = 15;
  localparam int          UIRP_FOLLOW_BIT  = 13;
  localparam int          UIRP_DIV_W       = 12;
  localparam int          UIRP_CAR_W       = 13;
  localparam int          UIRP_PW_W        = 13;

  // ---------------------------------------------------------------
  // reset values and frame counts
  // ---------------------------------------------------------------
  localparam logic [11:0] UIRP_DIV_RST   = 12'h001;
  localparam logic [12:0] UIRP_CAR_RST   = 13'h0001;
  localparam logic [12:0] UIRP_PW_RST    = 13'h0000;
  localparam logic [3:0]  UIRP_RX_MID    = 4'h7;
  localparam logic [3:0]  UIRP_PH_LAST   = 4'hf;
  localparam logic [3:0]  UIRP_FRM_PAR   = 4'hb;
  localparam logic [3:0]  UIRP_FRM_NOPAR = 4'ha;

  // control word, bits 9..0 in register order
  typedef struct packed {
    logic pin_type;
    logic set_carrier;
    logic set_pw;
    logic serial_on;
    logic ir_on;
    logic set_baud;
    logic user_bit;
    logic set_parity;
    logic rx_allow;
    logic tx_allow;
  } uirp_ctl_t;

  // parity-select settings
  typedef struct packed {
    logic carrier_on;
    logic mode_inv;
    logic mode_uart;
    logic polarity;
    logic par_en;
  } uirp_par_t;

  // status high byte, bits 15..10
  typedef struct packed {
    logic stop_missing;
    logic holding_free;
    logic char_available;
    logic parity_fault;
    logic overrun;
    logic irq_source;
  } uirp_stat_t;

  typedef enum logic {UIRP_IDLE, UIRP_RUN} uirp_st_t;

endpackage

// [rtl/uirp_top.sv]
// serial transceiver with infrared carrier and one pwm channel
// assumes synchronous pin inputs and a single-cycle strobe register port
// Summary of operation
// - bit rates reach at most 115200 bits per second.
// - parity generated and checked; data bit 0 enables, bit 5 picks even.
// - one stop bit sent; a missing received stop bit sets a flag.
// - data write with no rate, carrier or width select loads a character.
// - baud select loads a 12-bit divisor; rate is 115200 over divisor.
// - carrier select loads 13-bit count; carrier is 1.8432 MHz over twice it.
// - carrier write bit 15 selects single pulse, else continuous.
// - width select loads 13 bits; pulse high lasts value plus one ticks.
// - width-sync bit zero makes the negative output take settings too.
// - carrier mode bit 0 picks user bit or serial data as modulator.
// - carrier mode bit 1 inverts the output waveform.
// - pin-type bit routes serial output to port pin or positive pad.
// - status bit shows last interrupt source: 0 transmit, 1 receive.
// - status exposes overrun, parity fault, character ready, holding free.
// - separate allow bits gate transmit and receive requests.
// - serial and infrared functions enabled separately.
// - parity write bit 14 switches the infrared carrier.
// - pwm output is the carrier gated by the user bit, like infrared.
// - data read gives the received character low, zeros high.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module uirp_top
  import uirp_pkg::*;
#(
  parameter int CLK_HZ = 100_000_000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        serial_block_on,
  input  wire logic        serial_rx_line,
  output logic             serial_tx_line,
  output logic             pwm_positive_out,
  output logic             pwm_negative_out,
  output logic             positive_drive_pad,
  output logic             positive_pad_active,
  output logic             tx_irq_req,
  output logic             rx_irq_req
);

  // ---------------------------------------------------------------
  // elaboration checks and rate helpers
  // ---------------------------------------------------------------
  if (CLK_HZ <= UIRP_PW_HZ || CLK_HZ >= 2**27) begin : g_chk
    $error("uirp_top: clock rate unusable");
  end

  localparam logic [27:0] CLK_FULL = 28'(CLK_HZ);
  localparam logic [26:0] BASE_INC = 27'(UIRP_BASE_HZ);
  localparam logic [26:0] PW_INC   = 27'(UIRP_PW_HZ);

  // phase accumulator step, msb is the tick
  function automatic logic [27:0] acc_step(input logic [26:0] acc,
                                           input logic [26:0] inc);
    logic [27:0] s;
    s = {1'b0, acc} + {1'b0, inc};
    if (s >= CLK_FULL) acc_step = {1'b1, 27'(s - CLK_FULL)};
    else acc_step = {1'b0, s[26:0]};
  endfunction

  // parity bit for a character
  function automatic logic par_bit(input logic [7:0] d, input logic even);
    par_bit = even ? ^d : ~^d;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  uirp_ctl_t   ctl_r;
  uirp_par_t   par_r;
  uirp_stat_t  st_r;
  logic [11:0] div_r;
  logic [12:0] car_r, pw_r, neg_pw_r;
  logic        single_r, follow_r;
  logic [26:0] base_acc_r, pw_acc_r;
  logic        base_tick_r, pw_tick_r, b16_tick_r;
  logic [11:0] bdiv_cnt_r;
  logic [7:0]  hold_r, rx_buf_r;
  uirp_st_t    tx_st_r, rx_st_r;
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_cnt_r, tx_ph_r, rx_ph_r, rx_idx_r;
  logic [7:0]  rx_sh_r;
  logic        rx_par_r;
  logic        rx_prev_r;
  logic [12:0] car_cnt_r, pw_cnt_r, neg_cnt_r;
  logic        half_r, pulse_r, neg_pulse_r, shot_r;

  logic        wr_ctl, wr_data, rd_ctl, rd_data, wr_char, wr_car, wr_pw, on;
  logic        tx_load, tx_bit, rx_done, rx_bad, start, start_ok;
  logic [3:0]  rx_last;
  logic [11:0] div_lim;
  logic [12:0] car_lim;
  logic        ir_wave, pwm_wave, neg_wave, uart_line;
  logic [27:0] base_s, pw_s;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  assign wr_ctl  = wr && addr == UIRP_CTL_ADDR;
  assign wr_data = wr && addr == UIRP_DATA_ADDR;
  assign rd_ctl  = rd && addr == UIRP_CTL_ADDR;
  assign rd_data = rd && addr == UIRP_DATA_ADDR;
  assign wr_char = wr_data && !ctl_r.set_baud && !ctl_r.set_carrier
                   && !ctl_r.set_pw;
  assign wr_car  = wr_data && ctl_r.set_carrier;
  assign wr_pw   = wr_data && ctl_r.set_pw;
  assign on      = serial_block_on && ctl_r.serial_on;

  // control word and data-word settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r    <= '0;
      par_r    <= '0;
      div_r    <= UIRP_DIV_RST;
      car_r    <= UIRP_CAR_RST;
      pw_r     <= UIRP_PW_RST;
      neg_pw_r <= UIRP_PW_RST;
      single_r <= 1'b0;
      follow_r <= 1'b0;
    end else begin
      if (wr_ctl) ctl_r <= uirp_ctl_t'(wdata[9:0]);
      if (wr_data && ctl_r.set_parity) begin
        par_r.par_en     <= wdata[UIRP_PAR_EN_BIT];
        par_r.polarity   <= wdata[UIRP_PAR_POL_BIT];
        par_r.mode_uart  <= wdata[UIRP_MODE_LSB];
        par_r.mode_inv   <= wdata[UIRP_MODE_LSB+1];
        par_r.carrier_on <= wdata[UIRP_CAR_EN_BIT];
      end
      if (wr_data && ctl_r.set_baud) div_r <= wdata[UIRP_DIV_W-1:0];
      if (wr_car) begin
        car_r    <= wdata[UIRP_CAR_W-1:0];
        single_r <= wdata[UIRP_SINGLE_BIT];
      end
      if (wr_pw) begin
        pw_r     <= wdata[UIRP_PW_W-1:0];
        follow_r <= wdata[UIRP_FOLLOW_BIT];
        if (!wdata[UIRP_FOLLOW_BIT]) neg_pw_r <= wdata[UIRP_PW_W-1:0];
      end
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata <= 16'h0000;
    else if (rd_ctl) rdata <= {st_r, ctl_r};
    else if (rd_data) rdata <= {8'h00, rx_buf_r};
    else rdata <= 16'h0000;
  end

  // ---------------------------------------------------------------
  // tick generation
  // ---------------------------------------------------------------
  assign base_s  = acc_step(base_acc_r, BASE_INC);
  assign pw_s    = acc_step(pw_acc_r, PW_INC);
  assign div_lim = (div_r == 12'h000) ? 12'h001 : div_r;

  // carrier base and width clocks, then 16x bit-rate tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_acc_r  <= '0;
      pw_acc_r    <= '0;
      base_tick_r <= 1'b0;
      pw_tick_r   <= 1'b0;
      b16_tick_r  <= 1'b0;
      bdiv_cnt_r  <= 12'h000;
    end else begin
      base_acc_r  <= base_s[26:0];
      base_tick_r <= base_s[27];
      pw_acc_r    <= pw_s[26:0];
      pw_tick_r   <= pw_s[27];
      b16_tick_r  <= 1'b0;
      if (base_tick_r) begin
        if (bdiv_cnt_r >= div_lim - 12'h001) begin
          bdiv_cnt_r <= 12'h000;
          b16_tick_r <= 1'b1;
        end else begin
          bdiv_cnt_r <= bdiv_cnt_r + 12'h001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  assign tx_load = on && tx_st_r == UIRP_IDLE && !st_r.holding_free && !wr_char;
  assign tx_bit  = (tx_st_r == UIRP_RUN) ? tx_sh_r[0] : 1'b1;

  // holding register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_r <= 8'h00;
    else if (wr_char) hold_r <= wdata[7:0];
  end

  // frame shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_r  <= UIRP_IDLE;
      tx_sh_r  <= '1;
      tx_cnt_r <= 4'h0;
      tx_ph_r  <= 4'h0;
    end else begin
      case (tx_st_r)
        UIRP_IDLE: begin
          if (tx_load) begin
            tx_st_r <= UIRP_RUN;
            tx_ph_r <= 4'h0;
            if (par_r.par_en) begin
              tx_sh_r  <= {1'b1, par_bit(hold_r, par_r.polarity), hold_r, 1'b0};
              tx_cnt_r <= UIRP_FRM_PAR;
            end else begin
              tx_sh_r  <= {2'b11, hold_r, 1'b0};
              tx_cnt_r <= UIRP_FRM_NOPAR;
            end
          end
        end
        UIRP_RUN: begin
          if (b16_tick_r) begin
            tx_ph_r <= tx_ph_r + 4'h1;
            if (tx_ph_r == UIRP_PH_LAST) begin
              tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
              tx_cnt_r <= tx_cnt_r - 4'h1;
              if (tx_cnt_r == 4'h1) tx_st_r <= UIRP_IDLE;
            end
          end
        end
        default: tx_st_r <= UIRP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  assign rx_last = par_r.par_en ? 4'ha : 4'h9;
  assign rx_done = rx_st_r == UIRP_RUN && b16_tick_r && rx_ph_r == UIRP_RX_MID
                   && rx_idx_r == rx_last;
  assign rx_bad  = par_r.par_en && rx_par_r != par_bit(rx_sh_r, par_r.polarity);

  // previous line level, resets to idle high so reset gives no false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rx_prev_r <= 1'b1;
    else rx_prev_r <= serial_rx_line;
  end

  // mid-bit sampling, false starts dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_r  <= UIRP_IDLE;
      rx_ph_r  <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_sh_r  <= 8'h00;
      rx_par_r <= 1'b0;
    end else begin
      case (rx_st_r)
        UIRP_IDLE: begin
          if (on && !serial_rx_line && rx_prev_r) begin
            rx_st_r  <= UIRP_RUN;
            rx_ph_r  <= 4'h0;
            rx_idx_r <= 4'h0;
          end
        end
        UIRP_RUN: begin
          if (b16_tick_r) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (rx_ph_r == UIRP_RX_MID) begin
              rx_idx_r <= rx_idx_r + 4'h1;
              if (rx_idx_r == 4'h0 && serial_rx_line) rx_st_r <= UIRP_IDLE;
              else if (rx_idx_r != 4'h0 && rx_idx_r <= 4'h8)
                rx_sh_r <= {serial_rx_line, rx_sh_r[7:1]};
              else if (rx_idx_r == 4'h9 && par_r.par_en) rx_par_r <= serial_rx_line;
              if (rx_idx_r == rx_last) rx_st_r <= UIRP_IDLE;
            end
          end
        end
        default: rx_st_r <= UIRP_IDLE;
      endcase
    end
  end

  // received character buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rx_buf_r <= 8'h00;
    else if (rx_done) rx_buf_r <= rx_sh_r;
  end

  // status flags, hardware set wins over clear except holding free, where a character write wins over the load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r              <= '0;
      st_r.holding_free <= 1'b1;
    end else begin
      if (wr_char) st_r.holding_free <= 1'b0;
      else if (tx_load) st_r.holding_free <= 1'b1;
      st_r.char_available <= rx_done || (st_r.char_available && !rd_data);
      st_r.overrun <= (rx_done && st_r.char_available && !rd_data)
                      || (st_r.overrun && !rd_ctl);
      st_r.parity_fault <= (rx_done && rx_bad) || (st_r.parity_fault && !rd_ctl);
      st_r.stop_missing <= (rx_done && !serial_rx_line)
                           || (st_r.stop_missing && !rd_ctl);
      if (rx_done) st_r.irq_source <= 1'b1;
      else if (tx_load) st_r.irq_source <= 1'b0;
    end
  end

  // interrupt requests
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_irq_req <= 1'b0;
      rx_irq_req <= 1'b0;
    end else begin
      tx_irq_req <= ctl_r.tx_allow && st_r.holding_free;
      rx_irq_req <= ctl_r.rx_allow && st_r.char_available;
    end
  end

  // ---------------------------------------------------------------
  // carrier and pulse width
  // ---------------------------------------------------------------
  assign car_lim  = (car_r == 13'h0000) ? 13'h0001 : car_r;
  assign start    = base_tick_r && car_cnt_r >= car_lim - 13'h0001 && half_r;
  assign start_ok = start && serial_block_on && !(single_r && shot_r);

  // half-period divider of the base clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      car_cnt_r <= 13'h0000;
      half_r    <= 1'b0;
    end else if (base_tick_r) begin
      if (car_cnt_r >= car_lim - 13'h0001) begin
        car_cnt_r <= 13'h0000;
        half_r    <= !half_r;
      end else begin
        car_cnt_r <= car_cnt_r + 13'h0001;
      end
    end
  end

  // single-pulse latch, rearmed by a carrier or width write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) shot_r <= 1'b0;
    else if (wr_car || wr_pw) shot_r <= 1'b0;
    else if (start_ok) shot_r <= 1'b1;
  end

  // positive and negative pulse high time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_r     <= 1'b0;
      pw_cnt_r    <= 13'h0000;
      neg_pulse_r <= 1'b0;
      neg_cnt_r   <= 13'h0000;
    end else if (start_ok) begin
      pulse_r     <= 1'b1;
      pw_cnt_r    <= 13'h0000;
      neg_pulse_r <= 1'b1;
      neg_cnt_r   <= 13'h0000;
    end else if (pw_tick_r) begin
      if (pulse_r && pw_cnt_r == pw_r) pulse_r <= 1'b0;
      else if (pulse_r) pw_cnt_r <= pw_cnt_r + 13'h0001;
      if (neg_pulse_r && neg_cnt_r == neg_pw_r) neg_pulse_r <= 1'b0;
      else if (neg_pulse_r) neg_cnt_r <= neg_cnt_r + 13'h0001;
    end
  end

  // ---------------------------------------------------------------
  // output waveforms and pin routing
  // ---------------------------------------------------------------
  assign ir_wave   = par_r.carrier_on && ctl_r.ir_on && pulse_r
                     && (par_r.mode_uart ? !tx_bit : ctl_r.user_bit);
  assign pwm_wave  = par_r.carrier_on && pulse_r && ctl_r.user_bit;
  assign neg_wave  = par_r.carrier_on && neg_pulse_r && ctl_r.user_bit;
  assign uart_line = ctl_r.ir_on ? (ir_wave ^ par_r.mode_inv) : tx_bit;

  // registered pads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_tx_line      <= 1'b1;
      pwm_positive_out    <= 1'b0;
      pwm_negative_out    <= 1'b1;
      positive_drive_pad  <= 1'b0;
      positive_pad_active <= 1'b0;
    end else begin
      serial_tx_line      <= ctl_r.pin_type ? 1'b1 : uart_line;
      pwm_positive_out    <= pwm_wave ^ par_r.mode_inv;
      pwm_negative_out    <= !(neg_wave ^ par_r.mode_inv);
      positive_drive_pad  <= ctl_r.pin_type ? uart_line : (pwm_wave ^ par_r.mode_inv);
      positive_pad_active <= ctl_r.pin_type;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_data_high_zero: assert property (rd_data |=> rdata[15:8] == 8'h00)
    else $error("data read high byte not zero");
  a_start_low: assert property ($rose(tx_st_r == UIRP_RUN) |-> !tx_bit)
    else $error("start bit not low");
  a_stop_high: assert property (tx_st_r == UIRP_RUN && tx_cnt_r == 4'h1 |-> tx_bit)
    else $error("stop bit not high");
  a_char_load: assert property (wr_char |=> hold_r == $past(wdata[7:0]))
    else $error("character not loaded");
  a_div_load: assert property (wr_data && ctl_r.set_baud && !wr_ctl
    |=> div_r == $past(wdata[11:0]))
    else $error("divisor not loaded");
  a_rx_ready: assert property (rx_done |=> st_r.char_available
    and (!rd_data |=> st_r.char_available))
    else $error("ready flag lost");
  a_rx_gate: assert property (!ctl_r.rx_allow [*2] |-> !rx_irq_req)
    else $error("receive request while not allowed");
  a_pulse_len: assert property ($fell(pulse_r) && !$past(start_ok)
    |-> $past(pw_cnt_r) == $past(pw_r))
    else $error("pulse width wrong");
  a_neg_sync: assert property (wr_pw && !wdata[UIRP_FOLLOW_BIT]
    |=> neg_pw_r == pw_r)
    else $error("negative width not synchronised");
  a_pad_route: assert property (ctl_r.pin_type |=> positive_pad_active
    && serial_tx_line)
    else $error("pin routing wrong");
  a_overrun: assert property (rx_done && st_r.char_available && !rd_data
    |=> st_r.overrun)
    else $error("overrun not flagged");

endmodule

// [bench/uirp_remote.sv]
// remote serial transceiver model facing the controller's serial pins
// assumes the bit time of divisor one at a 100 MHz bench clock
`timescale 1ns/1ps
module uirp_remote #(
  parameter int BIT_CLKS = 868
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  // ---------------------------------------------------------------
  // framing tasks
  // ---------------------------------------------------------------
  // line rests high between frames
  initial line_out = 1'b1;

  // capture start, eight data lsb first, optional parity, stop
  task automatic recv(input bit par, output logic [7:0] v, output logic pb, output logic sb);
    pb = 1'b0;
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      v[i] = line_in;
    end
    if (par) begin
      repeat (BIT_CLKS) @(posedge clk);
      pb = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk);
    sb = line_in;
  endtask

  // send one frame with parity bit pb and stop level sb
  task automatic send(input logic [7:0] v, input logic pb, input logic sb);
    logic [10:0] f;
    f = {sb, pb, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
endmodule

// [bench/uirp_top_tb.sv]
// self-checking bench of the serial / infrared / pwm controller
// assumes the remote model runs at the divisor-one bit time
`timescale 1ns/1ps
module uirp_top_tb
  import uirp_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        blk_on = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, q;
  logic        rx_line, tx_line, pos, neg, pad, pad_on, tx_irq, rx_irq;
  logic [7:0]  b, d;
  logic        p, s;
  int          fails = 0, n_checks = 0, hi, nlo;

  uirp_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_block_on(blk_on), .serial_rx_line(rx_line),
    .serial_tx_line(tx_line), .pwm_positive_out(pos), .pwm_negative_out(neg),
    .positive_drive_pad(pad), .positive_pad_active(pad_on), .tx_irq_req(tx_irq),
    .rx_irq_req(rx_irq));
  uirp_remote u_rem (.clk(clk), .line_in(tx_line), .line_out(rx_line));

  // ---------------------------------------------------------------
  // clock, checks and bus tasks
  // ---------------------------------------------------------------
  always #5 clk = ~clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic par_bit(logic [7:0] v, logic [15:0] cfg);
    return cfg[0] & (cfg[5] ? ^v : ~^v);
  endfunction

  function automatic int hi_clks(int w);
    return int'((w + 1) * 100.0 / 65.536);
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  // parity set-up, character load, then serial on with both requests allowed
  task automatic tx_frame(input logic [15:0] cfg);
    b = 8'($urandom);
    wr_reg(UIRP_CTL_ADDR, 16'h0004);
    wr_reg(UIRP_DATA_ADDR, cfg);
    wr_reg(UIRP_CTL_ADDR, 16'h0000);
    wr_reg(UIRP_DATA_ADDR, {8'h00, b});
    fork
      u_rem.recv(cfg[0], d, p, s);
      wr_reg(UIRP_CTL_ADDR, 16'h0043);
    join
    check(16'(d), 16'(b));
    check(16'(p), 16'(par_bit(b, cfg)));
    check(16'(s), 16'h0001);
    check(16'(tx_irq), 16'h0001);
    repeat (900) @(posedge clk);
  endtask

  // remote sends a random frame, even parity unless pflip is set, then status is read
  task automatic rx_frame(input logic pflip, input logic stop, input logic [15:0] st);
    b = 8'($urandom);
    u_rem.send(b, ^b ^ pflip, stop);
    rd_reg(UIRP_CTL_ADDR, q);
    check(q, st);
  endtask

  // counts pwm high and negative-low cycles over one carrier period
  task automatic measure(input int e);
    hi = 0;
    nlo = 0;
    repeat (500) @(posedge clk);
    repeat (434) begin
      @(posedge clk);
      #1;
      hi += int'(pos === 1'b1);
      nlo += int'(neg === 1'b0);
    end
    check(16'(hi > e - 5 && hi < e + 5), 16'h0001);
    check(16'(nlo > e - 5 && nlo < e + 5), 16'h0001);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    void'($urandom(72667));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(16'({tx_line, pos, neg, pad, pad_on, tx_irq, rx_irq}), 16'h0050);
    rd_reg(UIRP_CTL_ADDR, q);
    check(q, 16'h4000);
    rd_reg(UIRP_DATA_ADDR, q);
    check(q, 16'h0000);
    rd_reg(8'h55, q);
    check(q, 16'h0000);
    wr_reg(UIRP_CTL_ADDR, 16'h0010);
    wr_reg(UIRP_DATA_ADDR, 16'h0001);
    tx_frame(16'h0000);
    tx_frame(16'h0021);
    rd_reg(UIRP_CTL_ADDR, q);
    check(q, 16'h4043);
    rx_frame(1'b0, 1'b1, 16'h6443);
    check(16'(rx_irq), 16'h0001);
    rd_reg(UIRP_DATA_ADDR, q);
    check(q, {8'h00, b});
    #1 check(16'(rx_irq), 16'h0000);
    rx_frame(1'b0, 1'b0, 16'he443);
    rd_reg(UIRP_DATA_ADDR, q);
    rx_frame(1'b0, 1'b1, 16'h6443);
    rx_frame(1'b1, 1'b1, 16'h7c43);
    rd_reg(UIRP_DATA_ADDR, q);
    check(q, {8'h00, b});
    wr_reg(UIRP_CTL_ADDR, 16'h0200);
    @(posedge clk);
    #1 check(16'({pad_on, tx_line, pad}), 16'h0007);
    wr_reg(UIRP_CTL_ADDR, 16'h0100);
    wr_reg(UIRP_DATA_ADDR, 16'h0004);
    wr_reg(UIRP_CTL_ADDR, 16'h0080);
    wr_reg(UIRP_DATA_ADDR, 16'h0040);
    wr_reg(UIRP_CTL_ADDR, 16'h0004);
    wr_reg(UIRP_DATA_ADDR, 16'h4000);
    wr_reg(UIRP_CTL_ADDR, 16'h0000);
    measure(0);
    wr_reg(UIRP_CTL_ADDR, 16'h0008);
    measure(hi_clks(64));
    wr_reg(UIRP_CTL_ADDR, 16'h000c);
    wr_reg(UIRP_DATA_ADDR, 16'h6000);
    wr_reg(UIRP_CTL_ADDR, 16'h0008);
    measure(434 - hi_clks(64));
    print_verdict();
  end
endmodule
